/* sar_adc_regs.svh */
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH

// ****************************************
// Result width and reset value
// ****************************************
`define RESULT_BITS 10
`define RESULT_RESET 10'h000
`define RESULT_MSB_TRIAL 10'h200

// ****************************************
// Channel select codes
// ****************************************
`define CHAN_EXT0 3'h0
`define CHAN_EXT3 3'h3
`define CHAN_CMP_REF 3'h4
`define CHAN_REF_0V6 3'h5
`define CHAN_REF_1V2 3'h6
`define CHAN_RESERVED 3'h7

// ****************************************
// Conversion clock select codes
// ****************************************
`define CLKSEL_DIV2 3'h0
`define CLKSEL_DIV4 3'h4
`define CLKSEL_DIV8 3'h1
`define CLKSEL_DIV16 3'h5
`define CLKSEL_DIV32 3'h2
`define CLKSEL_DIV64 3'h6
`define CLKSEL_RC_LOW 2'h3

// ****************************************
// Format and reference selects
// ****************************************
`define JUSTIFY_RIGHT 1'b1
`define REF_SUPPLY 1'b0
`define REF_EXT_PIN 1'b1

// ****************************************
// Timing counts
// ****************************************
`define CONV_TAD_COUNT 4'hb
`define ABORT_TAD_COUNT 4'h2
`define INSTR_CYCLE_CLKS 3'h4

`endif

/* sar_adc_pkg.sv */
`default_nettype none

`include "sar_adc_regs.svh"

package sar_adc_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RC_DELAY = 2'b01,
		ST_CONVERT = 2'b10,
		ST_ABORT_WAIT = 2'b11
	} conv_state_e;

	typedef struct packed {
		logic result_justify_select;
		logic positive_ref_select;
		logic [2:0] channel_select;
		logic [2:0] conv_clock_select;
	} ctrl_s;

	typedef struct packed {
		logic powered;
		logic mux_en;
		logic [2:0] mux_sel;
		logic ref_pos_sel;
		logic track;
		logic [`RESULT_BITS-1:0] trial;
	} analog_s;

endpackage

`default_nettype wire

/* conv_tick_gen.sv */
`timescale 1ns/10ps
`default_nettype none

`include "sar_adc_regs.svh"

module conv_tick_gen (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Control
	input wire logic run,
	input wire logic [2:0] clock_select,
	input wire logic rc_level,
	// Bit period strobe
	output logic tick
);

	logic [5:0] div_q;
	logic rc_prev_q;
	logic [5:0] mask;
	logic tick_div;
	logic tick_rc;
	logic rc_sel;

	// ****************************************
	// Divider mask per source
	// ****************************************
	assign rc_sel = (clock_select[1:0] == `CLKSEL_RC_LOW);
	assign mask = (clock_select == `CLKSEL_DIV2) ? 6'h01 :
		(clock_select == `CLKSEL_DIV4) ? 6'h03 :
		(clock_select == `CLKSEL_DIV8) ? 6'h07 :
		(clock_select == `CLKSEL_DIV16) ? 6'h0f :
		(clock_select == `CLKSEL_DIV32) ? 6'h1f : 6'h3f;
	assign tick_div = ((div_q & mask) == mask);
	// Rising edge of the already synchronised oscillator level
	assign tick_rc = rc_level & ~rc_prev_q;
	assign tick = run & (rc_sel ? tick_rc : tick_div);

	// Held at zero while idle so the first period is a full one
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div_q <= 6'h00;
			rc_prev_q <= 1'b0;
		end else begin
			div_q <= run ? 6'(div_q + 6'h01) : 6'h00;
			rc_prev_q <= rc_level;
		end
	end

endmodule

`default_nettype wire

/* sar_adc_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none

`include "sar_adc_regs.svh"

module sar_adc_sequencer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Configuration
	input wire sar_adc_pkg::ctrl_s ctrl,
	input wire logic converter_enable,
	// Software strobes on the start/status bit and flag
	input wire logic start_set,
	input wire logic start_clear,
	input wire logic conv_done_flag_clear,
	// Interrupt control and power state
	input wire logic conv_done_irq_enable,
	input wire logic sleep_active,
	// Analog side
	input wire logic rc_osc_in,
	input wire logic comparator_in,
	output var sar_adc_pkg::analog_s analog_out,
	// Status
	output logic start_busy,
	output logic conv_done_flag,
	output logic irq_req,
	output logic wake_req,
	output logic [7:0] result_high_byte,
	output logic [7:0] result_low_byte
);

	// ****************************************
	// State
	// ****************************************
	sar_adc_pkg::conv_state_e state_q;
	sar_adc_pkg::conv_state_e state_d;
	sar_adc_pkg::analog_s analog_d;
	logic go_q;
	logic go_d;
	logic flag_q;
	logic flag_d;
	logic sleep_off_q;
	logic sleep_off_d;
	logic [3:0] tad_cnt_q;
	logic [3:0] tad_cnt_d;
	logic [2:0] instr_cnt_q;
	logic [2:0] instr_cnt_d;
	logic [`RESULT_BITS-1:0] trial_q;
	logic [`RESULT_BITS-1:0] trial_d;
	logic [`RESULT_BITS-1:0] mask_q;
	logic [`RESULT_BITS-1:0] mask_d;
	logic [`RESULT_BITS-1:0] result_q;
	logic [`RESULT_BITS-1:0] result_d;
	logic [7:0] high_q;
	logic [7:0] low_q;

	// ****************************************
	// Synchronisers
	// ****************************************
	logic cmp_meta_q;
	logic cmp_sync_q;
	logic rc_meta_q;
	logic rc_sync_q;

	// Two cycles of comparator latency rule out the divide-by-two source
	// two-stage crossings
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cmp_meta_q <= 1'b0;
			cmp_sync_q <= 1'b0;
			rc_meta_q <= 1'b0;
			rc_sync_q <= 1'b0;
		end else begin
			cmp_meta_q <= comparator_in;
			cmp_sync_q <= cmp_meta_q;
			rc_meta_q <= rc_osc_in;
			rc_sync_q <= rc_meta_q;
		end
	end

	// ****************************************
	// Decode
	// ****************************************
	logic rc_sel;
	logic sleep_kill;
	logic powered;
	logic converting;
	logic run_tad;
	logic tick;
	logic start_ok;
	logic sw_abort;
	logic abort_any;
	logic last_bit;
	logic done;
	logic keep_bit;
	logic [`RESULT_BITS-1:0] decided;
	logic instr_done;
	logic abort_done;
	logic chan_valid;
	logic tick_run;

	assign rc_sel = (ctrl.conv_clock_select[1:0] == `CLKSEL_RC_LOW);
	assign sleep_kill = sleep_active & ~rc_sel;
	assign powered = converter_enable & ~sleep_off_q & ~sleep_kill;
	assign converting = (state_q == sar_adc_pkg::ST_RC_DELAY) | (state_q == sar_adc_pkg::ST_CONVERT);
	assign run_tad = (state_q == sar_adc_pkg::ST_CONVERT) | (state_q == sar_adc_pkg::ST_ABORT_WAIT);
	assign start_ok = (state_q == sar_adc_pkg::ST_IDLE) & go_q & powered;
	// software clear of the busy bit
	assign sw_abort = converting & start_clear & ~start_set;
	assign abort_any = converting & (sw_abort | ~converter_enable | sleep_kill);
	// bit decisions on periods 1 to 10
	assign last_bit = (tad_cnt_q == 4'(`CONV_TAD_COUNT - 4'h1));
	assign done = (state_q == sar_adc_pkg::ST_CONVERT) & tick & last_bit & ~abort_any;
	// comparator high keeps the trial bit
	assign keep_bit = cmp_sync_q;
	assign decided = keep_bit ? trial_q : (trial_q & ~mask_q);
	assign instr_done = (instr_cnt_q == 3'(`INSTR_CYCLE_CLKS - 3'h1));
	assign abort_done = tick & (tad_cnt_q == 4'(`ABORT_TAD_COUNT - 4'h1));
	// reserved channel leaves the mux open
	assign chan_valid = (ctrl.channel_select != `CHAN_RESERVED);
	// Divider restarts on an abort so the wait is two whole periods
	assign tick_run = run_tad & ~abort_any;

	// ****************************************
	// Bit period source
	// ****************************************
	// divider or RC edge per select code
	conv_tick_gen u_tick (
		.sys_clk(sys_clk),
		.rst(rst),
		.run(tick_run),
		.clock_select(ctrl.conv_clock_select),
		.rc_level(rc_sync_q),
		.tick(tick)
	);

	// ****************************************
	// Sequencer next state
	// ****************************************
	always_comb begin
		state_d = state_q;
		tad_cnt_d = tad_cnt_q;
		instr_cnt_d = 3'h0;
		trial_d = trial_q;
		mask_d = mask_q;
		result_d = result_q;
		case (state_q)
			sar_adc_pkg::ST_IDLE: begin
				tad_cnt_d = 4'h0;
				if (start_ok) begin
					trial_d = `RESULT_MSB_TRIAL;
					mask_d = `RESULT_MSB_TRIAL;
					if (rc_sel) begin
						state_d = sar_adc_pkg::ST_RC_DELAY;
					end else begin
						state_d = sar_adc_pkg::ST_CONVERT;
					end
				end
			end
			sar_adc_pkg::ST_RC_DELAY: begin
				instr_cnt_d = 3'(instr_cnt_q + 3'h1);
				if (abort_any) begin
					state_d = ~converter_enable ? sar_adc_pkg::ST_IDLE : sar_adc_pkg::ST_ABORT_WAIT;
				end else if (instr_done) begin
					state_d = sar_adc_pkg::ST_CONVERT;
				end
			end
			sar_adc_pkg::ST_CONVERT: begin
				if (abort_any) begin
					tad_cnt_d = 4'h0;
					state_d = ~converter_enable ? sar_adc_pkg::ST_IDLE : sar_adc_pkg::ST_ABORT_WAIT;
				end else if (tick) begin
					tad_cnt_d = 4'(tad_cnt_q + 4'h1);
					// First period only takes the hold
					if (tad_cnt_q != 4'h0) begin
						trial_d = decided | (mask_q >> 1);
						mask_d = mask_q >> 1;
					end
					if (last_bit) begin
						result_d = decided;
						tad_cnt_d = 4'h0;
						state_d = sar_adc_pkg::ST_IDLE;
					end
				end
			end
			sar_adc_pkg::ST_ABORT_WAIT: begin
				// two periods, then back to tracking
				if (~converter_enable) begin
					tad_cnt_d = 4'h0;
					state_d = sar_adc_pkg::ST_IDLE;
				end else if (abort_done) begin
					tad_cnt_d = 4'h0;
					state_d = sar_adc_pkg::ST_IDLE;
				end else if (tick) begin
					tad_cnt_d = 4'(tad_cnt_q + 4'h1);
				end
			end
			default: begin
				state_d = sar_adc_pkg::ST_IDLE;
				tad_cnt_d = 4'h0;
			end
		endcase
	end

	// ****************************************
	// Start/status bit, flag and power
	// ****************************************
	// hardware clears busy at completion
	// A new set in the same cycle wins while the converter is enabled
	assign go_d = (start_set & converter_enable) ? 1'b1 :
		(done | start_clear | ~converter_enable | (sleep_kill & converting)) ? 1'b0 : go_q;
	// only the software strobe clears it
	assign flag_d = done ? 1'b1 : (conv_done_flag_clear ? 1'b0 : flag_q);
	// Cleared the moment sleep ends, ready for the next start
	// RC run in sleep without interrupt
	// power stays off until sleep ends
	assign sleep_off_d = ~sleep_active ? 1'b0 :
		((done & rc_sel & ~conv_done_irq_enable) | sleep_kill) ? 1'b1 : sleep_off_q;

	// ****************************************
	// Analog outputs
	// ****************************************
	always_comb begin
		analog_d.powered = powered;
		// selected source to sample and hold
		analog_d.mux_en = powered & chan_valid;
		analog_d.mux_sel = ctrl.channel_select;
		analog_d.ref_pos_sel = ctrl.positive_ref_select;
		// tracking only in idle and RC delay, not in the bit periods or abort wait
		analog_d.track = powered & ((state_d == sar_adc_pkg::ST_IDLE) | (state_d == sar_adc_pkg::ST_RC_DELAY));
		analog_d.trial = trial_d;
	end

	// ****************************************
	// Result formatting
	// ****************************************
	logic [7:0] fmt_high;
	logic [7:0] fmt_low;
	logic right_just;

	// Layout follows the format bit now, not the one at completion
	// one means right justified
	assign right_just = (ctrl.result_justify_select == `JUSTIFY_RIGHT);
	assign fmt_high = right_just ? {6'h00, result_q[9:8]} : result_q[9:2];
	assign fmt_low = right_just ? result_q[7:0] : {result_q[1:0], 6'h00};

	// ****************************************
	// Registers
	// ****************************************
	// reset clears everything and stops
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= sar_adc_pkg::ST_IDLE;
			go_q <= 1'b0;
			flag_q <= 1'b0;
			sleep_off_q <= 1'b0;
			tad_cnt_q <= 4'h0;
			instr_cnt_q <= 3'h0;
		end else begin
			state_q <= state_d;
			go_q <= go_d;
			flag_q <= flag_d;
			sleep_off_q <= sleep_off_d;
			tad_cnt_q <= tad_cnt_d;
			instr_cnt_q <= instr_cnt_d;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			trial_q <= `RESULT_RESET;
			mask_q <= `RESULT_RESET;
			result_q <= `RESULT_RESET;
		end else begin
			trial_q <= trial_d;
			mask_q <= mask_d;
			result_q <= result_d;
		end
	end

	// Bytes trail a format change by one cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			high_q <= 8'h00;
			low_q <= 8'h00;
			analog_out <= '0;
		end else begin
			high_q <= fmt_high;
			low_q <= fmt_low;
			analog_out <= analog_d;
		end
	end

	// ****************************************
	// Status outputs
	// ****************************************
	assign start_busy = go_q;
	assign conv_done_flag = flag_q;
	assign irq_req = flag_q & conv_done_irq_enable;
	assign wake_req = flag_q & conv_done_irq_enable;
	assign result_high_byte = high_q;
	assign result_low_byte = low_q;

endmodule

`default_nettype wire

/* sar_adc_props.sv */
`timescale 1ns/10ps
`default_nettype none
module sar_adc_props (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Controls
	input wire sar_adc_pkg::ctrl_s ctrl,
	input wire logic converter_enable,
	input wire logic start_set,
	input wire logic start_clear,
	input wire logic conv_done_flag_clear,
	input wire logic conv_done_irq_enable,
	// Results
	input wire sar_adc_pkg::analog_s analog_out,
	input wire logic start_busy,
	input wire logic conv_done_flag,
	input wire logic irq_req,
	input wire logic wake_req,
	input wire logic [7:0] result_high_byte,
	input wire logic [7:0] result_low_byte
);
	logic jprev_q;
	logic jprev2_q;
	// Bytes lag a format change by a cycle
	wire j_steady = ctrl.result_justify_select == jprev_q && jprev_q == jprev2_q;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			jprev_q <= 1'b0;
			jprev2_q <= 1'b0;
		end else begin
			jprev_q <= ctrl.result_justify_select;
			jprev2_q <= jprev_q;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_irq_gate: assert property (
		irq_req == (conv_done_flag && conv_done_irq_enable) && wake_req == irq_req)
		else $error("interrupt request not flag and enable");
	a_flag_held: assert property (
		conv_done_flag && !conv_done_flag_clear |=> conv_done_flag)
		else $error("done flag dropped without clear");
	a_flag_cause: assert property (
		$rose(conv_done_flag) |-> $past(start_busy) && !start_busy)
		else $error("done flag without busy falling");
	a_start_taken: assert property (
		start_set && converter_enable && !start_clear |=> start_busy)
		else $error("start not taken");
	a_start_refused: assert property (
		!converter_enable && !start_busy |=> !start_busy)
		else $error("start taken while disabled");
	a_off_unpowered: assert property (
		!converter_enable |=> !analog_out.powered)
		else $error("powered while disabled");
	a_mux_chan: assert property (
		analog_out.mux_en && $stable(ctrl.channel_select) |-> analog_out.mux_sel == ctrl.channel_select)
		else $error("mux not on selected channel");
	a_reserved_chan: assert property (
		ctrl.channel_select == 3'h7 && $stable(ctrl.channel_select) |-> !analog_out.mux_en)
		else $error("reserved channel routed");
	a_ref_select: assert property (
		analog_out.powered && $stable(ctrl.positive_ref_select)
			|-> analog_out.ref_pos_sel == ctrl.positive_ref_select)
		else $error("reference select not followed");
	a_bytes_kept: assert property (
		!$stable({result_high_byte, result_low_byte}) |-> conv_done_flag || $past(conv_done_flag) || !j_steady)
		else $error("result changed without completion");
	a_unused_zero: assert property (
		j_steady |-> (ctrl.result_justify_select ? result_high_byte[7:2] == 6'h00 : result_low_byte[5:0] == 6'h00))
		else $error("unused result bits not zero");
endmodule
bind sar_adc_sequencer sar_adc_props u_props (.sys_clk, .rst, .ctrl, .converter_enable, .start_set, .start_clear,
	.conv_done_flag_clear, .conv_done_irq_enable, .analog_out, .start_busy, .conv_done_flag, .irq_req, .wake_req,
	.result_high_byte, .result_low_byte);
`default_nettype wire

/* sar_analog_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sar_analog_model (
	// Clock
	input wire logic sys_clk,
	// Converter side
	input wire sar_adc_pkg::analog_s analog_out,
	input wire logic [9:0] chan_level [8],
	// Answers
	output logic comparator_in,
	output logic rc_osc_in
);
	logic [9:0] held = 10'h000;
	logic noise_q = 1'b0;
	always @(posedge sys_clk) if (analog_out.track && analog_out.mux_en) held <= chan_level[analog_out.mux_sel];
	always @(posedge sys_clk) noise_q <= ~noise_q;
	// trial against held sample; unselected input gives no stable answer
	assign comparator_in = (analog_out.powered && analog_out.mux_en) ? (held >= analog_out.trial) : noise_q;
	// Free running, unrelated to the system clock
	initial rc_osc_in = 1'b0;
	always #30 rc_osc_in = ~rc_osc_in;
endmodule
`default_nettype wire

/* sar_adc_sequencer_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module sar_adc_sequencer_tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	sar_adc_pkg::ctrl_s ctrl = '0;
	logic converter_enable = 1'b0;
	logic start_set = 1'b0;
	logic start_clear = 1'b0;
	logic conv_done_flag_clear = 1'b0;
	logic conv_done_irq_enable = 1'b0;
	logic sleep_active = 1'b0;
	logic rc_osc_in, comparator_in, start_busy, conv_done_flag, irq_req, wake_req;
	sar_adc_pkg::analog_s analog_out;
	logic [7:0] result_high_byte, result_low_byte;
	logic [9:0] chan_level [8] = '{default: 10'h000};
	logic [31:0] seed = 32'h39;
	logic [15:0] last_bytes = 16'h0000;
	int failures = 0;
	int samples_checked = 0;
	int cyc;
	sar_adc_sequencer DUT (.sys_clk, .rst, .ctrl, .converter_enable, .start_set, .start_clear,
		.conv_done_flag_clear, .conv_done_irq_enable, .sleep_active, .rc_osc_in, .comparator_in,
		.analog_out, .start_busy, .conv_done_flag, .irq_req, .wake_req, .result_high_byte, .result_low_byte);
	sar_analog_model u_model (.sys_clk, .analog_out, .chan_level, .comparator_in, .rc_osc_in);
	always #2.5 sys_clk = ~sys_clk;
	function logic [31:0] next_rand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [15:0] exp_bytes(input logic j, input logic [9:0] r);
		return j ? {6'h00, r} : {r, 6'h00};
	endfunction
	task step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task pulse_start();
		start_set = 1'b1;
		step(1);
		start_set = 1'b0;
	endtask
	task clear_flag();
		conv_done_flag_clear = 1'b1;
		step(1);
		chk(conv_done_flag, 16'h0);
		conv_done_flag_clear = 1'b0;
	endtask
	task wait_idle();
		cyc = 0;
		while (start_busy === 1'b1 && cyc < 2000) begin
			step(1);
			cyc++;
		end
		if (cyc >= 2000) begin
			failures++;
			$display("mismatch at %0t: busy never fell", $time);
		end
	endtask
	// ****************************************
	// One conversion with all result checks except the bytes at clock code 0
	// ****************************************
	task run_conv(input logic [2:0] cs, input logic [2:0] ch);
		logic [31:0] r;
		int n;
		r = next_rand();
		ctrl = '{r[0], r[1], ch, cs};
		conv_done_irq_enable = r[2];
		chan_level[ch] = r[21:12];
		step(20);
		pulse_start();
		chk(start_busy, 16'h1);
		wait_idle();
		n = 2 << ({1'b0, cs[1:0], 1'b0} + cs[2]);
		// Four-cycle instruction delay, then 11 edges of the 60 ns oscillator
		if (cs[1:0] == 2'h3) chk(cyc inside {[125:138]}, 16'h1);
		else chk(cyc inside {[11*n-2:11*n+3]}, 16'h1);
		step(1);
		chk({start_busy, conv_done_flag}, 16'h1);
		chk({wake_req, irq_req}, {14'h0, r[2], r[2]});
		step(1);
		// Fastest clock leaves the comparator too little settling time
		if (cs != 3'h0) begin
			chk({result_high_byte, result_low_byte}, exp_bytes(r[0], chan_level[ch]));
			ctrl.result_justify_select = ~r[0];
			step(2);
			last_bytes = exp_bytes(~r[0], chan_level[ch]);
			chk({result_high_byte, result_low_byte}, last_bytes);
		end
		clear_flag();
		$display("test conversion with clock code %0d done", cs);
	endtask
	task print_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		print_verdict();
	end
	initial begin
		step(8);
		rst = 1'b0;
		chk({start_busy, conv_done_flag, irq_req}, 16'h0);
		chk({result_high_byte, result_low_byte}, 16'h0);
		pulse_start();
		step(1);
		chk(start_busy, 16'h0);
		converter_enable = 1'b1;
		step(2);
		$display("test reset and disabled start done");
		for (int i = 0; i < 8; i++) run_conv(i[2:0], 3'(next_rand() % 7));
		ctrl.conv_clock_select = 3'h1;
		pulse_start();
		step(30);
		start_clear = 1'b1;
		step(1);
		start_clear = 1'b0;
		chk(start_busy, 16'h0);
		step(15);
		chk(analog_out.track, 16'h0);
		step(1);
		chk(analog_out.track, 16'h1);
		chk({result_high_byte, result_low_byte}, last_bytes);
		chk(conv_done_flag, 16'h0);
		$display("test software abort done");
		ctrl.channel_select = 3'h7;
		step(20);
		pulse_start();
		step(30);
		sleep_active = 1'b1;
		step(3);
		chk({start_busy, conv_done_flag, analog_out.powered}, 16'h0);
		sleep_active = 1'b0;
		step(40);
		chk({result_high_byte, result_low_byte}, last_bytes);
		$display("test sleep abort done");
		ctrl = '{1'b1, 1'b0, 3'h0, 3'h3};
		conv_done_irq_enable = 1'b0;
		step(20);
		pulse_start();
		sleep_active = 1'b1;
		wait_idle();
		step(2);
		chk({conv_done_flag, analog_out.powered, irq_req}, 16'h4);
		chk({result_high_byte, result_low_byte}, exp_bytes(1'b1, chan_level[0]));
		sleep_active = 1'b0;
		step(3);
		clear_flag();
		$display("test conversion in sleep done");
		ctrl.conv_clock_select = 3'h5;
		pulse_start();
		step(20);
		converter_enable = 1'b0;
		step(2);
		chk({start_busy, conv_done_flag, analog_out.powered}, 16'h0);
		chk({result_high_byte, result_low_byte}, exp_bytes(1'b1, chan_level[0]));
		converter_enable = 1'b1;
		step(2);
		$display("test enable loss done");
		ctrl.conv_clock_select = 3'h5;
		pulse_start();
		step(20);
		rst = 1'b1;
		step(1);
		chk({start_busy, conv_done_flag, analog_out.powered}, 16'h0);
		chk({result_high_byte, result_low_byte}, 16'h0);
		rst = 1'b0;
		step(2);
		chk({start_busy, analog_out.track}, 16'h1);
		$display("test reset during conversion done");
		print_verdict();
	end
endmodule
`default_nettype wire
